/* design/touch_adc_consts.svh */
/*
  Constants of the touch-screen converter serial control: control byte
  fields, power codes, sequence counts and the FIFO shape.
  Assumes inclusion by touch_adc_pkg.sv and the design file only.
*/
// Notes on behaviour
// - Back-to-back conversions at fifteen clocks each, eleven in eight-bit mode
// - Results are unsigned straight binary codes
// - Eight-bit conversions end four clocks sooner
// - Code 11 always powered, 00 auto-down
// - Single-ended: switches closed only while acquiring
// - Differential: switches closed acquiring and converting
// - Power-down 00: corner grounded, sense connected
// - Touch in power-down pulls pen interrupt low
// - Measuring: pen diode grounded, sense disconnected
// - Channel 110, code 00: touch reads ones
// - Chip select high: data output high-impedance
// - Control byte MSB first, start bit one
// - Code 01 like 00, pen off; 10 reserved
// - Twelve conversion clocks, thirteenth shows last bit
// - New byte every 15th or 11th clock
`ifndef TOUCH_ADC_CONSTS_SVH
`define TOUCH_ADC_CONSTS_SVH

// Control bits after the start bit, as received (7 bits)
`define CB_CHAN_HI     6
`define CB_CHAN_LO     4
`define CB_MODE8       3
`define CB_REF_SINGLE  2
`define CB_PD_HI       1
`define CB_PD_LO       0
`define CB_LAST_CNT    3'h6
`define CB_ACQ_CNT     3'h2

// Power codes and the touch readback channel
`define PD_AUTO        2'h0
`define PD_NO_PEN      2'h1
`define PD_FULL        2'h3
`define CHAN_PEN_READ  3'h6
`define CTRL_RESET     7'h00

// Falling edges after the byte: one busy edge, then the result bits
`define LAST_FALL_12   4'hd
`define LAST_FALL_8    4'h9
`define FIRST_BIT_FALL 4'h2
// Rising edges after the byte before a new start bit is looked for
`define GAP_12         4'h7
`define GAP_8          4'h3

`define RES_W          12
`define FIFO_DEPTH     8

`endif

/* design/touch_adc_pkg.sv */
/*
  Types shared by the converter serial control.
  Assumes touch_adc_consts.svh is on the include path.
*/
`include "touch_adc_consts.svh"

package touch_adc_pkg;

  // Decoded control byte, start bit stripped
  typedef struct packed {
    logic [2:0] chan;
    logic       mode8;
    logic       ref_single;
    logic [1:0] pd;
  } ctrl_s;

  // Receiver: looking for a start bit, shifting the byte, spacing gap
  typedef enum logic [1:0] {RX_SEARCH, RX_SHIFT, RX_GAP} rx_state_e;

endpackage : touch_adc_pkg

/* design/touch_adc_serial_control.sv */
/*
  Serial control, conversion sequencing, power mode and pen-touch logic
  of a 12-bit touch-screen converter, with the sample FIFO in front of it.
  Assumes: link pins are asynchronous and sampled by clk_i (50 MHz);
  sample words arrive synchronous to clk_i from the analog front end.
*/
`include "touch_adc_consts.svh"

module touch_adc_sample_fifo #(
  parameter int WIDTH = `RES_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // Honest full and empty from the fill count
  assign in_ready_o  = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem[rp_r];
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  always_comb begin
    wp_nxt  = push ? wp_r + AW'(1) : wp_r;
    rp_nxt  = pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointers wrap freely since DEPTH is a power of two
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) mem[wp_r] <= in_data_i;
  end
endmodule : touch_adc_sample_fifo

module touch_adc_serial_control
  import touch_adc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // Serial link pins
  input  wire logic               serial_clock_in_i,
  input  wire logic               chip_select_n_i,
  input  wire logic               serial_data_in_i,
  output logic                    serial_data_o,
  output logic                    serial_data_oe_n_o,
  // Open-drain pen interrupt
  output logic                    pen_touch_irq_n_o,
  output logic                    pen_touch_irq_n_oe_n_o,
  // Analog front end
  input  wire logic               panel_touched_i,
  input  wire logic               sample_valid_i,
  input  wire logic [`RES_W-1:0]  sample_data_i,
  output logic                    sample_ready_o,
  // Switch and power controls
  output ctrl_s                   ctrl_o,
  output logic                    panel_drive_o,
  output logic                    lower_right_drive_o,
  output logic                    pen_diode_gnd_o,
  output logic                    panel_sense_input_o,
  output logic                    powered_o,
  output logic                    sample_hold_o
);
  // Two-flop synchronisers plus one edge-history flop for the clock pin
  logic sclk_q1, sclk_q2, sclk_q3, cs_q1, cs_q2, din_q1, din_q2, tch_q1, tch_q2;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      {sclk_q1, sclk_q2, sclk_q3} <= 3'h0;
      {cs_q1, cs_q2}              <= 2'h3;
      {din_q1, din_q2}            <= 2'h0;
      {tch_q1, tch_q2}            <= 2'h0;
    end else begin
      {sclk_q1, sclk_q2, sclk_q3} <= {serial_clock_in_i, sclk_q1, sclk_q2};
      {cs_q1, cs_q2}              <= {chip_select_n_i, cs_q1};
      {din_q1, din_q2}            <= {serial_data_in_i, din_q1};
      {tch_q1, tch_q2}            <= {panel_touched_i, tch_q1};
    end
  end

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_q2 & ~sclk_q3 & ~cs_q2;
  assign sclk_fall = ~sclk_q2 & sclk_q3 & ~cs_q2;

  rx_state_e          rx_state_r, rx_state_nxt;
  logic [2:0]         bit_cnt_r, bit_cnt_nxt;
  logic [5:0]         sr_r, sr_nxt;
  logic [3:0]         gap_cnt_r, gap_cnt_nxt, fall_cnt_r, fall_cnt_nxt, last_fall_r, last_fall_nxt;
  ctrl_s              ctrl_r, ctrl_nxt, byte_in;
  logic               acq_r, acq_nxt, conv_r, conv_nxt, dout_r, dout_nxt, byte_done;
  logic [`RES_W-1:0]  out_sr_r, out_sr_nxt, result;
  logic               fifo_valid;
  logic [`RES_W-1:0]  fifo_data;

  // Sample words queue up here; the converter takes one per control byte
  touch_adc_sample_fifo #(.WIDTH(`RES_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (sample_valid_i),
    .in_data_i   (sample_data_i),
    .in_ready_o  (sample_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (byte_done)
  );

  // last control bit arrives on this rising edge
  assign byte_done = (rx_state_r == RX_SHIFT) && sclk_rise && (bit_cnt_r == `CB_LAST_CNT);
  assign byte_in   = ctrl_s'({sr_r, din_q2});

  // Result word, MSB aligned; an empty queue converts as zero
  always_comb begin
    result = fifo_valid ? fifo_data : '0;
    if (byte_in.chan == `CHAN_PEN_READ && byte_in.pd == `PD_AUTO) begin
      result = {`RES_W{tch_q2}};
    end else if (byte_in.mode8) begin
      // eight-bit result keeps the top bits
      result = {fifo_data[`RES_W-1:4] & {8{fifo_valid}}, 4'h0};
    end
  end

  // Receiver next state
  always_comb begin
    rx_state_nxt  = rx_state_r;
    bit_cnt_nxt   = bit_cnt_r;
    sr_nxt        = sr_r;
    gap_cnt_nxt   = gap_cnt_r;
    ctrl_nxt      = ctrl_r;
    acq_nxt       = acq_r;
    conv_nxt      = conv_r;
    fall_cnt_nxt  = fall_cnt_r;
    last_fall_nxt = last_fall_r;
    out_sr_nxt    = out_sr_r;
    dout_nxt      = dout_r;
    if (cs_q2) begin
      // deselect drops the sequence, keeps the power choice
      rx_state_nxt = RX_SEARCH;
      acq_nxt      = 1'b0;
      conv_nxt     = 1'b0;
      dout_nxt     = 1'b0;
    end else begin
      if (sclk_rise) begin
        case (rx_state_r)
          RX_SEARCH: begin
            // ignore data until a one arrives
            if (din_q2) begin
              rx_state_nxt = RX_SHIFT;
              bit_cnt_nxt  = 3'h0;
            end
          end
          RX_SHIFT: begin
            sr_nxt      = {sr_r[4:0], din_q2};
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            // acquisition opens once the channel is known
            if (bit_cnt_r == `CB_ACQ_CNT) begin
              ctrl_nxt.chan = {sr_r[1:0], din_q2};
              acq_nxt       = 1'b1;
            end
            if (byte_done) begin
              ctrl_nxt      = byte_in;
              acq_nxt       = 1'b0;
              conv_nxt      = 1'b1;
              fall_cnt_nxt  = 4'h0;
              gap_cnt_nxt   = 4'h0;
              out_sr_nxt    = result;
              // twelve bits, or eight in eight-bit mode, plus a busy edge
              last_fall_nxt = byte_in.mode8 ? `LAST_FALL_8 : `LAST_FALL_12;
              rx_state_nxt  = RX_GAP;
            end
          end
          RX_GAP: begin
            // start search reopens for the 15th / 11th clock
            // this overlap gives the 15-clock cadence
            gap_cnt_nxt = gap_cnt_r + 4'h1;
            if (gap_cnt_r == (ctrl_r.mode8 ? `GAP_8 : `GAP_12) - 4'h1) begin
              rx_state_nxt = RX_SEARCH;
            end
          end
          default: rx_state_nxt = RX_SEARCH;
        endcase
      end
      if (sclk_fall) begin
        // result bits change on falling edges, MSB first
        dout_nxt = 1'b0;
        if (conv_r) begin
          fall_cnt_nxt = fall_cnt_r + 4'h1;
          if (fall_cnt_r + 4'h1 >= `FIRST_BIT_FALL) begin
            dout_nxt   = out_sr_r[`RES_W-1];
            out_sr_nxt = {out_sr_r[`RES_W-2:0], 1'b0};
          end
          // conversion ends with the last bit shown
          if (fall_cnt_r + 4'h1 == last_fall_r) conv_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_state_r  <= RX_SEARCH;
      bit_cnt_r   <= 3'h0;
      sr_r        <= 6'h00;
      gap_cnt_r   <= 4'h0;
      ctrl_r      <= ctrl_s'(`CTRL_RESET);
      acq_r       <= 1'b0;
      conv_r      <= 1'b0;
      fall_cnt_r  <= 4'h0;
      last_fall_r <= `LAST_FALL_12;
      out_sr_r    <= '0;
      dout_r      <= 1'b0;
    end else begin
      rx_state_r  <= rx_state_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      sr_r        <= sr_nxt;
      gap_cnt_r   <= gap_cnt_nxt;
      ctrl_r      <= ctrl_nxt;
      acq_r       <= acq_nxt;
      conv_r      <= conv_nxt;
      fall_cnt_r  <= fall_cnt_nxt;
      last_fall_r <= last_fall_nxt;
      out_sr_r    <= out_sr_nxt;
      dout_r      <= dout_nxt;
    end
  end

  // Power, switches and pen path; reserved code 10 acts as 01
  logic measuring, pd_auto, pen_pull;
  assign measuring = acq_r | conv_r;
  assign pd_auto   = (ctrl_r.pd == `PD_AUTO);
  // full power code or any active phase
  assign powered_o = measuring | (ctrl_r.pd == `PD_FULL);
  assign panel_drive_o = acq_r | (conv_r & ~ctrl_r.ref_single);
  // corner and sense only in code 00 power-down
  assign lower_right_drive_o = ~powered_o & pd_auto;
  assign pen_diode_gnd_o     = measuring;
  assign panel_sense_input_o = ~powered_o & pd_auto;
  // touch pulls the open-drain line low
  assign pen_pull               = lower_right_drive_o & tch_q2;
  assign pen_touch_irq_n_o      = 1'b0;
  assign pen_touch_irq_n_oe_n_o = ~pen_pull;
  assign sample_hold_o          = conv_r;
  assign ctrl_o                 = ctrl_r;
  assign serial_data_oe_n_o = cs_q2;
  assign serial_data_o      = dout_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_byte_done;
    (rx_state_r == RX_SHIFT) && sclk_rise && bit_cnt_r == 3'h6;
  endsequence
  sequence s_conv_end;
    conv_r && sclk_fall && !cs_q2 && (fall_cnt_r + 4'h1 == last_fall_r);
  endsequence

  AST_HIZ_DESELECT: assert property (cs_q2 |-> serial_data_oe_n_o)
    else $error("data output driven while deselected");
  AST_FULL_POWER: assert property (ctrl_r.pd == 2'h3 |-> powered_o)
    else $error("full power code but powered down");
  AST_AUTO_DOWN: assert property (ctrl_r.pd == 2'h0 && !acq_r && !conv_r |-> !powered_o)
    else $error("auto power-down not taken when idle");
  // Overlapped acquisition of the next byte may close the switches, so it is excluded
  AST_SINGLE_OPEN: assert property (conv_r && !acq_r && ctrl_r.ref_single |-> !panel_drive_o)
    else $error("single-ended switches closed in conversion");
  AST_DIFF_CLOSED: assert property (measuring && !ctrl_r.ref_single |-> panel_drive_o)
    else $error("differential switches open while measuring");
  AST_PEN_PATH: assert property (!powered_o && pd_auto |-> lower_right_drive_o && panel_sense_input_o)
    else $error("pen path not set in power-down");
  AST_PEN_PULL: assert property (!powered_o && ctrl_r.pd == 2'h0 && tch_q2 |-> !pen_touch_irq_n_oe_n_o)
    else $error("touch did not pull pen line");
  AST_NO_PEN_01: assert property (ctrl_r.pd == 2'h1 |-> pen_touch_irq_n_oe_n_o && !lower_right_drive_o)
    else $error("pen path active in code 01");
  AST_MEAS_ISOLATE: assert property (measuring |-> pen_diode_gnd_o && !panel_sense_input_o)
    else $error("sense connected while measuring");
  AST_PEN_READBACK: assert property (s_byte_done ##0 (byte_in.chan == 3'h6 && byte_in.pd == 2'h0)
      |=> out_sr_r == {12{$past(tch_q2)}})
    else $error("touch readback word wrong");
  AST_CONV_LENGTH: assert property (s_conv_end |-> (ctrl_r.mode8 ? fall_cnt_r == 4'h8 : fall_cnt_r == 4'hc))
    else $error("conversion length wrong for mode");
  AST_BYTE_LOAD: assert property (s_byte_done |=> conv_r && rx_state_r == RX_GAP && fall_cnt_r == 4'h0)
    else $error("byte did not start conversion");
  AST_DOUT_ON_FALL: assert property (!cs_q2 && $changed(dout_r) && $past(!cs_q2) |-> $past(sclk_fall))
    else $error("data output changed away from falling edge");
  AST_DESELECT_RESET: assert property (cs_q2 |=> rx_state_r == RX_SEARCH && !conv_r)
    else $error("sequence survived deselect");
  AST_GAP_REOPEN: assert property ($rose(rx_state_r == RX_SEARCH) && !$past(cs_q2)
      |-> $past(gap_cnt_r) == (ctrl_r.mode8 ? 4'h2 : 4'h6))
    else $error("start search reopened at wrong clock");
endmodule : touch_adc_serial_control

/* test/tb_top.sv */
/*
  Self-checking bench of the converter serial control.
  Assumes the host model drives the link and reports each result.
*/
module tb_top
  import touch_adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_oe_n, pen_o, pen_oe_n, touched = 1'b0;
  logic s_valid = 1'b0, s_ready, drive, lr, diode, sense, powered, hold;
  logic sdo_hold = 1'b0;
  logic [11:0] s_data = 12'h000;
  logic [11:0] host_res;
  logic [31:0] seed = 32'hfaca54d8;
  ctrl_s ctrl_o;
  logic [11:0] fifo_q[$];
  logic [11:0] exp_q[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  wire pen_line = pen_oe_n ? 1'b1 : pen_o; // External pull-up
  wire sdo_line = sdo_oe_n ? ~sdo_hold : sdo;

  always #10 clk_i = ~clk_i;

  // Released data line shows the inverse of its last bit
  always @(posedge clk_i) if (!sdo_oe_n) sdo_hold <= sdo;

  touch_adc_serial_control uut (
    .clk_i(clk_i), .reset_i(reset_i), .serial_clock_in_i(sclk),
    .chip_select_n_i(cs_n), .serial_data_in_i(sdi), .serial_data_o(sdo),
    .serial_data_oe_n_o(sdo_oe_n), .pen_touch_irq_n_o(pen_o),
    .pen_touch_irq_n_oe_n_o(pen_oe_n), .panel_touched_i(touched),
    .sample_valid_i(s_valid), .sample_data_i(s_data), .sample_ready_o(s_ready),
    .ctrl_o(ctrl_o), .panel_drive_o(drive), .lower_right_drive_o(lr),
    .pen_diode_gnd_o(diode), .panel_sense_input_o(sense), .powered_o(powered),
    .sample_hold_o(hold));

  touch_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
    .sdo_i(sdo_line), .res_o(host_res));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Random channel that avoids the touch readback code
  function logic [2:0] rch();
    logic [31:0] r;
    r = rnd();
    return (r[2:0] == 3'h6) ? 3'h1 : r[2:0];
  endfunction : rch

  function logic [7:0] mk(input logic [2:0] ch, input logic m8, sr, input logic [1:0] pd);
    return {1'b1, ch, m8, sr, pd};
  endfunction : mk

  function logic [11:0] exp_of(input logic [7:0] c, input logic [11:0] s);
    if (c[6:4] == 3'h6 && c[1:0] == 2'h0)
      return touched ? (c[3] ? 12'h0ff : 12'hfff) : 12'h000;
    return c[3] ? {4'h0, s[11:4]} : s;
  endfunction : exp_of

  task chk(input logic [11:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task chkb(input logic got, exp);
    chk({11'h000, got}, {11'h000, exp});
  endtask : chkb

  task stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // Push random words until the FIFO refuses
  task fill();
    logic [31:0] r;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      r = rnd();
      #1 s_valid = 1'b1;
      s_data = r[11:0];
      #1 if (!s_ready) break;
      fifo_q.push_back(s_data);
    end
    s_valid = 1'b0;
    chkb(s_ready, 1'b0);
  endtask : fill

  // Note expectations, run one frame, then check the resting state
  task run(input logic [7:0] c [4], input int n, input int p);
    logic [7:0] l;
    // Start off the clock edge so the link pins never race the synchronisers
    @(posedge clk_i);
    #1;
    for (int k = 0; k < n; k++)
      exp_q.push_back(exp_of(c[k], fifo_q.size() > 0 ? fifo_q.pop_front() : 12'h000));
    u_host.xfer(c, n, p);
    repeat (10) @(posedge clk_i);
    #1;
    l = c[n - 1];
    chkb(exp_q.size() == 0, 1'b1);
    chkb(sdo_oe_n, 1'b1);
    chk({5'h00, ctrl_o}, {5'h00, l[6:0]});
    chkb(powered, l[1:0] == 2'h3);
    if (l[1:0] != 2'h3) chkb(lr, l[1:0] == 2'h0);
    if (l[1:0] == 2'h0) chkb(sense, 1'b1);
    chkb(pen_line, !(touched && l[1:0] == 2'h0));
  endtask : run

  // Each reported result against the oldest note
  always @(u_host.got_ev) begin
    // Let the port copy of the result settle before looking at it
    #1;
    if (exp_q.size() == 0) chk(host_res, 12'hbad);
    else chk(host_res, exp_q.pop_front());
  end

  // Switch state while converting, per reference mode, sampled away from the launch edge
  always @(negedge clk_i) begin
    if (!reset_i && hold && !uut.acq_r && ctrl_o.chan != 3'h6) chkb(drive, !ctrl_o.ref_single);
    if (!reset_i && uut.acq_r) chkb(drive, 1'b1);
  end

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: timeout", $time);
      stop_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    #1 reset_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    chkb(sdo_oe_n, 1'b1);
    chkb(powered, 1'b0);
    chkb(lr, 1'b1);
    fill();
    run('{mk(rch(), 1'h0, 1'h1, 2'h3), mk(rch(), 1'h0, 1'h0, 2'h3),
          mk(rch(), 1'h0, 1'h1, 2'h3), 8'h00}, 3, 15);
    fill();
    touched = 1'b1;
    run('{mk(rch(), 1'h1, 1'h0, 2'h1), mk(rch(), 1'h1, 1'h1, 2'h2),
          mk(rch(), 1'h1, 1'h0, 2'h1), 8'h00}, 3, 11);
    run('{mk(3'h6, 1'h0, 1'h0, 2'h0), mk(3'h6, 1'h1, 1'h0, 2'h0), 8'h00, 8'h00}, 2, 24);
    touched = 1'b0;
    run('{mk(3'h6, 1'h0, 1'h1, 2'h0), 8'h00, 8'h00, 8'h00}, 1, 24);
    stop_test();
  end
endmodule : tb_top

/* test/touch_host_model.sv */
/*
  Behavioural serial host that faces the converter's link pins.
  Assumes the bench calls xfer hierarchically and watches got_ev.
*/
module touch_host_model (
  // Link pins driven by the host
  output logic        sclk_o,
  output logic        cs_n_o,
  output logic        sdi_o,
  // Result line from the device
  input  wire logic   sdo_i,
  // Last assembled result
  output logic [11:0] res_o
);
  timeunit 1ns;
  timeprecision 100ps;

  event got_ev;

  // Link clock stands still low outside frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
    res_o  = 12'h000;
  end

  // One frame of n conversions, a new byte every p link clocks
  task automatic xfer(input logic [7:0] c [4], input int n, input int p);
    int e;
    int k;
    int off;
    int w;
    logic [11:0] acc [4];
    cs_n_o = 1'b0;
    #100;
    for (e = 1; e <= (n - 1) * p + 21; e++) begin
      sdi_o = 1'b0;
      for (k = 0; k < n; k++) begin
        off = e - k * p;
        if (off >= 1 && off <= 8) sdi_o = c[k][8 - off];
      end
      // one 160 ns rate serves both modes, inside the allowance
      #80 sclk_o = 1'b1;
      // sample late in the high phase
      #60;
      for (k = 0; k < n; k++) begin
        off = e - k * p;
        w   = c[k][3] ? 8 : 12;
        if (off == 10) acc[k] = 12'h000;
        if (off >= 10 && off < 10 + w) acc[k] = {acc[k][10:0], sdo_i};
        if (off == 9 + w) begin
          res_o = acc[k];
          -> got_ev;
        end
      end
      #20 sclk_o = 1'b0;
    end
    #100 cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // Released line must not keep its last level
  endtask : xfer
endmodule : touch_host_model
